// ---- rtl/compact_timer_map.svh ----
// Summary of operation
// - Clock select: sys/4, sys, high/16, high/64, subsidiary, external rise (110) or fall (111).
// - Reserved clock code 101 gives no count clock; the counter freezes.
// - Counts only while on; rising on clears count, falling on holds it.
// - Compare-match mode: rising on forces the pin to the initial level.
// - Period value compares count bits 9..7; zero means 1024 clocks, overflow.
// - Mode field: 00 compare-match, 10 PWM, 11 timer/counter, 01 undefined.
// - Compare-match A event: pin unchanged, low, high or toggled per output function.
// - PWM: 00 inactive level, 01 active level, 10 waveform, 11 undefined.
// - Initial-level bit sets the pre-match level, or the PWM active level.
// - Polarity bit inverts the output pin; no effect in timer/counter mode.
// - PWM swap bit: zero gives P period and A duty, one the reverse.
// - Clear select outside PWM: one clears on A match, zero on P match or overflow.
// - Count readable: low byte bits 7..0, high byte bits 1..0, rest zero.
// - Compare A held as low and high bytes, unused high bits read zero.
// - Compare-match with clear select zero raises both A and P flags.
// - Outside PWM, clear select one raises only the A flag, never the P flag.
// - Outside PWM, clear select one with compare A zero overflows at 3FF without A flag.
// - In compare-match mode only A matches and turn-on change the output pin.
// - Timer/counter mode leaves the pin undriven yet still raises flags.
// - Ten-bit up-counter advanced by the selected clock, compared continuously.
// - Pause bit holds the count; clearing it resumes from that value.
// - Low bytes pass a buffer: committed on high write, latched on high read.
`ifndef COMPACT_TIMER_MAP_SVH
`define COMPACT_TIMER_MAP_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_CONTROL_0 12'h000
`define ADDR_CONTROL_1 12'h004
`define ADDR_COUNT_LOW 12'h008
`define ADDR_COUNT_HIGH 12'h00c
`define ADDR_CMPA_LOW 12'h010
`define ADDR_CMPA_HIGH 12'h014
`define ADDR_STATUS 12'h018

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTRL0_PAUSE_BIT 7
`define CTRL0_ON_BIT 3
`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h00
`define COUNT_MAX 10'h3ff
`define CLK_SYS_DIV 2'h3
`define CLK_HIGH16_DIV 4'hf
`define CLK_HIGH64_DIV 6'h3f

`endif

// ---- rtl/compact_timer_pkg.sv ----
package compact_timer_pkg;

   // Operating mode
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_UNDEF = 2'b01,
      MODE_PWM = 2'b10,
      MODE_TIMER = 2'b11
   } op_mode_t;

   // Clock source codes
   typedef enum logic [2:0] {
      CLK_SYS_QUARTER = 3'b000,
      CLK_SYS = 3'b001,
      CLK_HIGH_16 = 3'b010,
      CLK_HIGH_64 = 3'b011,
      CLK_SUB = 3'b100,
      CLK_RESERVED = 3'b101,
      CLK_EXT_RISE = 3'b110,
      CLK_EXT_FALL = 3'b111
   } clk_src_t;

   // Control byte 0
   typedef struct packed {
      logic counterPause;
      clk_src_t clockSourceSelect;
      logic counterOnOff;
      logic [2:0] periodCompareValue;
   } control0_t;

   // Control byte 1
   typedef struct packed {
      op_mode_t operatingModeSelect;
      logic [1:0] outputFunctionSelect;
      logic outputInitialLevel;
      logic outputPolarityInvert;
      logic periodDutySwap;
      logic counterClearSelect;
   } control1_t;

   // Output pin group
   typedef struct packed {
      logic pinA;
      logic pinB;
      logic pinEnable;
   } timer_pins_t;

endpackage

// ---- rtl/compact_timer.sv ----
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "compact_timer_map.svh"

module compact_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock sources
   input wire logic subClockTick,
   input wire logic highClockTick,
   input wire logic externalCountInput,
   // Output pins and events
   output compact_timer_pkg::timer_pins_t timerPins,
   output logic compareAMatchFlag,
   output logic comparePMatchFlag
);

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   compact_timer_pkg::control0_t ctrl0;
   compact_timer_pkg::control1_t ctrl1;
   logic [9:0] count;
   logic [9:0] compareAValue;
   logic [7:0] lowBuffer;
   logic onPrev;
   logic pinLevel;
   logic [5:0] prescale;
   logic [2:0] extSync;
   logic subSync1, subSync2, highSync1, highSync2, highPrev;
   logic [3:0] highDiv;
   logic [5:0] high64Div;

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wire busWrite = psel && penable && pwrite;
   wire busRead = psel && penable && !pwrite;
   // Buffer snapshot at setup, the same edge that captures prdata, so the
   // high and low bytes of the count always come from one count value
   wire busSetupRead = psel && !penable && !pwrite;
   wire hitCtrl0 = paddr == `ADDR_CONTROL_0;
   wire hitCtrl1 = paddr == `ADDR_CONTROL_1;
   wire hitCntLo = paddr == `ADDR_COUNT_LOW;
   wire hitCntHi = paddr == `ADDR_COUNT_HIGH;
   wire hitCmpLo = paddr == `ADDR_CMPA_LOW;
   wire hitCmpHi = paddr == `ADDR_CMPA_HIGH;
   wire hitStatus = paddr == `ADDR_STATUS;
   wire mapped = hitCtrl0 | hitCtrl1 | hitCntLo | hitCntHi | hitCmpLo | hitCmpHi | hitStatus;

   // Mode and control decode
   // Undefined code 01 decodes to none of these, so the pin simply holds
   wire compareMode = ctrl1.operatingModeSelect == compact_timer_pkg::MODE_COMPARE;
   wire pwmMode = ctrl1.operatingModeSelect == compact_timer_pkg::MODE_PWM;
   wire timerMode = ctrl1.operatingModeSelect == compact_timer_pkg::MODE_TIMER;
   wire onRise = ctrl0.counterOnOff && !onPrev;

   // ----------------------------------------------------------------------
   // Clock source selection
   // ----------------------------------------------------------------------
   // Prescale free-runs so switching source never restarts a slow divider
   wire highEdge = highSync2 && !highPrev;
   wire extRise = extSync[1] && !extSync[2];
   wire extFall = !extSync[1] && extSync[2];
   wire sysQuarter = prescale[1:0] == `CLK_SYS_DIV;
   wire high16 = highEdge && highDiv == `CLK_HIGH16_DIV;
   wire high64 = highEdge && high64Div == `CLK_HIGH64_DIV;
   wire subEdge = subSync2;

   function automatic logic pickTick(input compact_timer_pkg::clk_src_t sel,
         input logic q, input logic h16, input logic h64, input logic s,
         input logic er, input logic ef);
      unique case (sel)
         compact_timer_pkg::CLK_SYS_QUARTER: pickTick = q;
         compact_timer_pkg::CLK_SYS: pickTick = 1'b1;
         compact_timer_pkg::CLK_HIGH_16: pickTick = h16;
         compact_timer_pkg::CLK_HIGH_64: pickTick = h64;
         compact_timer_pkg::CLK_SUB: pickTick = s;
         compact_timer_pkg::CLK_RESERVED: pickTick = 1'b0;
         compact_timer_pkg::CLK_EXT_RISE: pickTick = er;
         compact_timer_pkg::CLK_EXT_FALL: pickTick = ef;
      endcase
   endfunction

   wire srcTick = pickTick(ctrl0.clockSourceSelect, sysQuarter, high16, high64,
      subEdge, extRise, extFall);
   // Count only when on and not paused
   wire tick = srcTick && ctrl0.counterOnOff && !ctrl0.counterPause;

   // ----------------------------------------------------------------------
   // Comparators
   // ----------------------------------------------------------------------
   // Matches are evaluated on the value the counter is about to take
   wire [9:0] countInc = count + 10'h001;
   wire pZero = ctrl0.periodCompareValue == 3'h0;
   wire pHit = pZero ? (count == `COUNT_MAX)
      : (countInc == {ctrl0.periodCompareValue, 7'h00});
   wire aZero = compareAValue == 10'h000;
   wire aHit = aZero ? 1'b0 : (countInc == compareAValue);
   wire overflow = count == `COUNT_MAX;
   // PWM ignores clear select and clears on the period comparator
   wire pwmPeriodHit = ctrl1.periodDutySwap ? (aHit || (aZero && overflow)) : pHit;
   wire clearHit = pwmMode ? pwmPeriodHit
      : ctrl1.counterClearSelect ? (aHit || overflow) : pHit;
   wire aEvent = tick && aHit;
   wire pEvent = tick && pHit && (pwmMode || !ctrl1.counterClearSelect);
   wire [9:0] next_count = onRise ? 10'h000 : !tick ? count
      : clearHit ? 10'h000 : countInc;

   // ----------------------------------------------------------------------
   // PWM waveform
   // ----------------------------------------------------------------------
   // Duty as 10-bit threshold; duty at or past the period gives full active
   wire [9:0] dutyThresh = ctrl1.periodDutySwap
      ? {ctrl0.periodCompareValue, 7'h00} : compareAValue;
   wire dutyFull = ctrl1.periodDutySwap ? pZero : 1'b0;
   wire pwmActive = dutyFull || (next_count < dutyThresh);

   // Compare-match pin action on A match
   function automatic logic actLevel(input logic [1:0] fn, input logic cur);
      unique case (fn)
         2'b00: actLevel = cur;
         2'b01: actLevel = 1'b0;
         2'b10: actLevel = 1'b1;
         2'b11: actLevel = !cur;
      endcase
   endfunction

   wire next_pinCmp = onRise ? ctrl1.outputInitialLevel
      : aEvent ? actLevel(ctrl1.outputFunctionSelect, pinLevel) : pinLevel;
   wire pwmLevel = (ctrl1.outputFunctionSelect == 2'b10) ? pwmActive
      : (ctrl1.outputFunctionSelect == 2'b01);
   // Active level set by initial-level bit
   wire pwmPin = ctrl1.outputInitialLevel ? pwmLevel : !pwmLevel;
   wire next_pinLevel = compareMode ? next_pinCmp : pwmMode ? pwmPin : pinLevel;
   wire pinOut = next_pinLevel ^ ctrl1.outputPolarityInvert;
   wire pinDrive = ctrl0.counterOnOff && !timerMode;

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   wire [7:0] readByte = hitCtrl0 ? ctrl0 : hitCtrl1 ? ctrl1
      : (hitCntLo || hitCmpLo) ? lowBuffer
      : hitCntHi ? {6'h00, count[9:8]}
      : hitCmpHi ? {6'h00, compareAValue[9:8]}
      : hitStatus ? {6'h00, pinLevel, ctrl0.counterOnOff} : 8'h00;

   // ----------------------------------------------------------------------
   // Synchronisers for pin and foreign-clock inputs
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         extSync <= 3'h0;
         subSync1 <= 1'b0;
         subSync2 <= 1'b0;
         highSync1 <= 1'b0;
         highSync2 <= 1'b0;
         highPrev <= 1'b0;
      end else begin
         extSync <= {extSync[1:0], externalCountInput};
         subSync1 <= subClockTick;
         subSync2 <= subSync1;
         highSync1 <= highClockTick;
         highSync2 <= highSync1;
         highPrev <= highSync2;
      end
   end

   // Prescalers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prescale <= 6'h00;
         highDiv <= 4'h0;
         high64Div <= 6'h00;
      end else begin
         prescale <= prescale + 6'h01;
         highDiv <= highEdge ? highDiv + 4'h1 : highDiv;
         high64Div <= highEdge ? high64Div + 6'h01 : high64Div;
      end
   end

   // Control and compare registers; compare A low commits on high write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl0 <= `CTRL0_RESET;
         ctrl1 <= `CTRL1_RESET;
         compareAValue <= 10'h000;
         lowBuffer <= 8'h00;
      end else begin
         if (busWrite && hitCtrl0) ctrl0 <= pwdata[7:0];
         if (busWrite && hitCtrl1) ctrl1 <= pwdata[7:0];
         if (busWrite && hitCmpLo) lowBuffer <= pwdata[7:0];
         if (busWrite && hitCmpHi) compareAValue <= {pwdata[1:0], lowBuffer};
         if (busSetupRead && hitCntHi) lowBuffer <= count[7:0];
         if (busSetupRead && hitCmpHi) lowBuffer <= compareAValue[7:0];
      end
   end

   // Counter, pin and one-cycle match flags
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= 10'h000;
         onPrev <= 1'b0;
         pinLevel <= 1'b0;
         compareAMatchFlag <= 1'b0;
         comparePMatchFlag <= 1'b0;
         timerPins <= '0;
      end else begin
         count <= next_count;
         onPrev <= ctrl0.counterOnOff;
         pinLevel <= next_pinLevel;
         compareAMatchFlag <= aEvent && !onRise;
         comparePMatchFlag <= pEvent && !onRise;
         timerPins <= '{pinA: pinOut, pinB: pinOut, pinEnable: pinDrive};
      end
   end

   // Bus answer, zero wait state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= (psel && !penable && !pwrite) ? {24'h00_0000, readByte} : prdata;
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   a_on_rise_clears: assert property (onRise |=> count == 10'h000)
      else $error("counter not cleared by turn-on");
   a_off_holds: assert property (!ctrl0.counterOnOff && !onRise |=> $stable(count))
      else $error("counter moved while off");
   // A turn-on edge still clears the count while paused or unclocked
   a_pause_holds: assert property (ctrl0.counterPause && !onRise |=> count == $past(count))
      else $error("counter moved while paused");
   a_reserved_frozen: assert property (
      ctrl0.clockSourceSelect == compact_timer_pkg::CLK_RESERVED && !onRise |=> $stable(count))
      else $error("counter moved with no clock");
   a_flag_pulse: assert property (compareAMatchFlag |=> !compareAMatchFlag)
      else $error("match flag longer than one cycle");
   a_no_p_flag: assert property (
      !pwmMode && ctrl1.counterClearSelect && $stable(ctrl1) |=> !comparePMatchFlag)
      else $error("period flag with clear select one");
   a_pin_initial: assert property (compareMode && onRise |=> pinLevel == $past(ctrl1.outputInitialLevel))
      else $error("pin not reset to initial level");
   a_pin_idle: assert property (compareMode && !aEvent && !onRise |=> $stable(pinLevel))
      else $error("pin changed without compare A match");
   a_timer_undriven: assert property (timerMode |=> !timerPins.pinEnable)
      else $error("pin driven in timer mode");
   a_flag_count: assert property (compareAMatchFlag |-> count == compareAValue || count == 10'h000)
      else $error("compare A flag at wrong count");


   // ----------------------------------------------------------------------
   // Counter and clearing
   // ----------------------------------------------------------------------

   // Period flag is a pulse as well
   a_p_flag_pulse: assert property (comparePMatchFlag |=> !comparePMatchFlag)
      else $error("period flag longer than one cycle");

   // Plain tick advances by exactly one
   a_count_step: assert property (tick && !clearHit && !onRise |=> count == $past(count) + 10'h001)
      else $error("counter did not step by one");

   // Clear on P match with clear select zero
   a_p_clears: assert property (
      compareMode && !ctrl1.counterClearSelect && pEvent && !onRise |=> count == 10'h000)
      else $error("period match did not clear");

   // Clear on A match with clear select one
   a_a_clears: assert property (
      compareMode && ctrl1.counterClearSelect && aEvent && !onRise |=> count == 10'h000)
      else $error("compare A match did not clear");

   // Compare A of zero wraps with no A flag
   a_wrap_silent: assert property (
      ctrl1.counterClearSelect && aZero && !pwmMode |=> !compareAMatchFlag)
      else $error("A flag with compare A zero");

   // PWM period owner clears the count
   a_swap_period: assert property (
      pwmMode && ctrl1.periodDutySwap && aEvent && !onRise |=> count == 10'h000)
      else $error("A period did not clear");

   a_pwm_p_period: assert property (
      pwmMode && !ctrl1.periodDutySwap && pEvent && !onRise |=> count == 10'h000)
      else $error("P period did not clear");

   // ----------------------------------------------------------------------
   // Output pin
   // ----------------------------------------------------------------------

   // Timer mode leaves the level alone
   a_timer_pin_hold: assert property (timerMode |=> $stable(pinLevel))
      else $error("pin level moved in timer mode");

   // Undefined mode does nothing to the pin
   a_undef_pin_hold: assert property (
      ctrl1.operatingModeSelect == compact_timer_pkg::MODE_UNDEF |=> $stable(pinLevel))
      else $error("pin level moved in undefined mode");

   // Fixed PWM levels follow the active-level bit
   a_pwm_active: assert property (
      pwmMode && ctrl1.outputFunctionSelect == 2'b01
      |=> pinLevel == $past(ctrl1.outputInitialLevel))
      else $error("pwm active level wrong");

   a_pwm_inactive: assert property (
      pwmMode && ctrl1.outputFunctionSelect == 2'b00
      |=> pinLevel == !$past(ctrl1.outputInitialLevel))
      else $error("pwm inactive level wrong");

   // Pin shows the level through the polarity bit
   a_pin_polarity: assert property (
      timerPins.pinA == (pinLevel ^ $past(ctrl1.outputPolarityInvert)))
      else $error("pin polarity wrong");

   // Both pins carry one signal
   a_pin_pair: assert property (timerPins.pinA == timerPins.pinB)
      else $error("pin pair differs");

   // Stopped timer releases the pin
   a_drive_off: assert property (!ctrl0.counterOnOff |=> !timerPins.pinEnable)
      else $error("pin driven while off");

   // ----------------------------------------------------------------------
   // Register side
   // ----------------------------------------------------------------------

   // Compare A moves only on a high-byte write
   a_cmp_hold: assert property (!(busWrite && hitCmpHi) |=> $stable(compareAValue))
      else $error("compare A changed without high write");

   // Unused read bits stay zero
   a_read_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");

   c_overflow: cover property (tick && count == `COUNT_MAX);
   c_match_a: cover property (compareAMatchFlag);
   c_match_p: cover property (comparePMatchFlag);
   c_pwm_run: cover property (pwmMode && tick ##1 timerPins.pinEnable);
   c_toggle: cover property (compareMode && aEvent && ctrl1.outputFunctionSelect == 2'b11);

endmodule // compact_timer

// ---- tb/timer_pin_partner.sv ----
`timescale 1ns/100ps

module timer_pin_partner (
   // Clock
   input wire logic clk,
   // Timer side
   input wire compact_timer_pkg::timer_pins_t timerPins,
   output logic externalCountInput,
   output logic subClockTick,
   output logic highClockTick,
   // Board-level pin
   output logic pinWire
);
   // Other clocks stay quiet; only the count pin is exercised
   initial begin
      externalCountInput = 1'b0;
      subClockTick = 1'b0;
      highClockTick = 1'b0;
   end

   // Pull-up takes the pin when the timer lets go of it
   assign pinWire = timerPins.pinEnable ? timerPins.pinA : 1'b1;

   // Slow pulses, so the two-stage sync never misses an edge
   task automatic edges(input int n);
      repeat (n) begin
         @(posedge clk) externalCountInput <= 1'b1;
         repeat (4) @(posedge clk);
         externalCountInput <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule // timer_pin_partner

// ---- tb/compact_timer_tb.sv ----
`timescale 1ns/100ps
`include "compact_timer_map.svh"

module compact_timer_tb;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic subClockTick, highClockTick, externalCountInput, pinWire;
   logic compareAMatchFlag, comparePMatchFlag;
   compact_timer_pkg::timer_pins_t timerPins;
   int nMismatch = 0, nTests = 0, aCount = 0, pCount = 0, cycles = 0;

   // ----------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------
   compact_timer dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .subClockTick(subClockTick),
      .highClockTick(highClockTick), .externalCountInput(externalCountInput),
      .timerPins(timerPins), .compareAMatchFlag(compareAMatchFlag),
      .comparePMatchFlag(comparePMatchFlag));
   timer_pin_partner far (.clk(clk), .timerPins(timerPins),
      .externalCountInput(externalCountInput), .subClockTick(subClockTick),
      .highClockTick(highClockTick), .pinWire(pinWire));

   // 200 MHz clock, flag tally and hang guard
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (compareAMatchFlag === 1'b1) aCount++;
      if (comparePMatchFlag === 1'b1) pCount++;
      if (++cycles == 20000) begin
         nMismatch++;
         endOfTest();
      end
   end

   // ----------------------------------------------------------------
   // Access and check tasks
   // ----------------------------------------------------------------
   task automatic endOfTest;
      $display("comparisons %0d mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         nMismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Setup, access held until pready, then one idle cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk) penable <= 1'b1;
      // Only pready or the bench timeout ends this wait
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      logic [31:0] d;
      logic e;
      apb(1'b1, a, {24'h0, v}, d, e);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      chk(d, x);
   endtask

   // High byte first, so the low byte comes from the same snapshot
   task automatic rdCnt(output logic [9:0] v);
      logic [31:0] h, l;
      logic e;
      apb(1'b0, `ADDR_COUNT_HIGH, 32'h0, h, e);
      apb(1'b0, `ADDR_COUNT_LOW, 32'h0, l, e);
      v = {h[1:0], l[7:0]};
   endtask

   task automatic waitFlag(input bit selP, output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((selP ? comparePMatchFlag : compareAMatchFlag) !== 1'b1 && n < 3000);
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      logic [11:0] regs [6] = '{`ADDR_CONTROL_0, `ADDR_CONTROL_1, `ADDR_COUNT_HIGH,
                                `ADDR_COUNT_LOW, `ADDR_CMPA_HIGH, `ADDR_CMPA_LOW};
      logic [1:0] io [5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b10};
      logic oc [5] = '{1, 1, 0, 0, 0};
      logic pol [5] = '{0, 0, 0, 0, 1};
      logic aft [5] = '{1, 0, 1, 1, 0};
      logic [31:0] d;
      logic e;
      logic [9:0] v1, v2;
      int n;
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      // Reset values, read-only count, unmapped slot
      foreach (regs[i]) rdc(regs[i], 32'h0);
      wr(`ADDR_COUNT_HIGH, 8'h03);
      rdc(`ADDR_COUNT_HIGH, 32'h0);
      apb(1'b0, 12'h01c, 32'h0, d, e);
      chk({e, d}, {1'b1, 32'h0});
      $display("reset and map done");
      // Low byte staged until the high byte is written
      wr(`ADDR_CMPA_LOW, 8'h34);
      wr(`ADDR_CMPA_HIGH, 8'hff);
      wr(`ADDR_CMPA_LOW, 8'h56);
      rdc(`ADDR_CMPA_HIGH, 32'h3);
      rdc(`ADDR_CMPA_LOW, 32'h34);
      wr(`ADDR_CMPA_LOW, 8'h10);
      wr(`ADDR_CMPA_HIGH, 8'h00);
      $display("compare buffer done");
      // Every match action, clear on A; turned off before each change
      foreach (io[i]) begin
         wr(`ADDR_CONTROL_0, 8'h10);
         wr(`ADDR_CONTROL_1, {2'b00, io[i], oc[i], pol[i], 2'b01});
         pCount = 0;
         wr(`ADDR_CONTROL_0, 8'h18);
         repeat (2) @(posedge clk);
         chk(timerPins, {oc[i] ^ pol[i], oc[i] ^ pol[i], 1'b1});
         waitFlag(1'b0, n);
         chk(timerPins, {aft[i], aft[i], 1'b1});
         waitFlag(1'b0, n);
         chk(32'(n), 32'd16);
         chk(32'(pCount), 32'd0);
      end
      $display("compare output done");
      // Pause, stop and reserved clock all freeze the count
      wr(`ADDR_CONTROL_0, 8'h98);
      rdCnt(v1);
      repeat (20) @(posedge clk);
      rdCnt(v2);
      chk(32'(v2), 32'(v1));
      wr(`ADDR_CONTROL_0, 8'h10);
      rdCnt(v1);
      repeat (20) @(posedge clk);
      rdCnt(v2);
      chk(32'(v2), 32'(v1));
      wr(`ADDR_CONTROL_0, 8'h58);
      repeat (20) @(posedge clk);
      rdCnt(v1);
      chk(32'(v1), 32'h0);
      $display("hold and freeze done");
      // Timer mode: pin released, period from the top three bits
      wr(`ADDR_CONTROL_0, 8'h10);
      wr(`ADDR_CONTROL_1, 8'hc0);
      wr(`ADDR_CONTROL_0, 8'h19);
      aCount = 0;
      chk({timerPins.pinEnable, pinWire}, 2'b01);
      waitFlag(1'b1, n);
      waitFlag(1'b1, n);
      chk(32'(n), 32'd128);
      chk(32'(aCount > 0), 32'd1);
      wr(`ADDR_CONTROL_0, 8'h10);
      wr(`ADDR_CONTROL_0, 8'h18);
      waitFlag(1'b1, n);
      waitFlag(1'b1, n);
      chk(32'(n), 32'd1024);
      wr(`ADDR_CONTROL_0, 8'h01);
      wr(`ADDR_CONTROL_0, 8'h09);
      waitFlag(1'b1, n);
      waitFlag(1'b1, n);
      chk(32'(n), 32'd512);
      $display("timer mode done");
      // Compare A zero with clear on A: wraps silently
      wr(`ADDR_CONTROL_0, 8'h10);
      wr(`ADDR_CONTROL_1, 8'h01);
      wr(`ADDR_CMPA_LOW, 8'h00);
      wr(`ADDR_CMPA_HIGH, 8'h00);
      wr(`ADDR_CONTROL_0, 8'h18);
      aCount = 0;
      pCount = 0;
      repeat (1100) @(posedge clk);
      chk({aCount[15:0], pCount[15:0]}, 32'h0);
      $display("overflow done");
      // External pin, rising then falling edges
      wr(`ADDR_CONTROL_0, 8'h10);
      wr(`ADDR_CONTROL_1, 8'hc0);
      wr(`ADDR_CONTROL_0, 8'h60);
      wr(`ADDR_CONTROL_0, 8'h68);
      far.edges(5);
      rdCnt(v1);
      chk(32'(v1), 32'd5);
      wr(`ADDR_CONTROL_0, 8'h70);
      wr(`ADDR_CONTROL_0, 8'h78);
      far.edges(3);
      rdCnt(v1);
      chk(32'(v1), 32'd3);
      $display("external clock done");
      // PWM fixed levels, active high
      wr(`ADDR_CONTROL_0, 8'h70);
      wr(`ADDR_CONTROL_1, 8'h88);
      wr(`ADDR_CONTROL_0, 8'h18);
      repeat (4) @(posedge clk);
      chk(32'(timerPins.pinA), 32'd0);
      wr(`ADDR_CONTROL_0, 8'h10);
      wr(`ADDR_CONTROL_1, 8'h98);
      wr(`ADDR_CONTROL_0, 8'h18);
      repeat (4) @(posedge clk);
      chk(32'(timerPins.pinA), 32'd1);
      $display("pwm levels done");
      // PWM waveform: period 128 from P, duty 64 from A, active high
      wr(`ADDR_CONTROL_0, 8'h11);
      wr(`ADDR_CMPA_LOW, 8'h40);
      wr(`ADDR_CMPA_HIGH, 8'h00);
      wr(`ADDR_CONTROL_1, 8'ha8);
      wr(`ADDR_CONTROL_0, 8'h19);
      waitFlag(1'b1, n);
      chk(32'(timerPins.pinA), 32'd1);
      repeat (70) @(posedge clk);
      chk(32'(timerPins.pinA), 32'd0);
      $display("pwm waveform done");
      endOfTest();
   end
endmodule // compact_timer_tb
